// [inc/bti_cfg.svh]
`ifndef BTI_CFG_SVH
`define BTI_CFG_SVH

// Register offsets on the serial register port.
`define BTI_OFS_MODE        8'h01
`define BTI_OFS_STATUS      8'h02
`define BTI_OFS_IRQ_EN      8'h03
`define BTI_OFS_CONFIG      8'h04
`define BTI_OFS_SINK_SEL    8'h05
`define BTI_OFS_OFF_TIME    8'h06
`define BTI_OFS_DIM_TIME    8'h07
`define BTI_OFS_FADE        8'h08

// Mode register field positions.
`define BTI_MODE_BL_ON      0
`define BTI_MODE_AUTO       1
`define BTI_MODE_DIM        4
`define BTI_MODE_ACTIVE     5

// Status and interrupt enable positions (same layout in both).
`define BTI_IRQ_MAIN        0
`define BTI_IRQ_SECOND      1
`define BTI_IRQ_OVERVOLT    2
`define BTI_IRQ_THERMAL     3
`define BTI_IRQ_SHORT       4

// Configuration register field positions.
`define BTI_CFG_FADE_OVR    0
`define BTI_CFG_LAW_LO      1
`define BTI_CFG_LAW_HI      2
`define BTI_CFG_LVL_LO      3
`define BTI_CFG_LVL_HI      4
`define BTI_CFG_SECOND_EN   5
`define BTI_CFG_STEER       6

// Writable bit masks; reserved bits read zero and ignore writes.
`define BTI_MASK_MODE       8'h33
`define BTI_MASK_STATUS     8'h1f
`define BTI_MASK_IRQ_EN     8'h1f
`define BTI_MASK_CONFIG     8'h7f
`define BTI_MASK_SINK_SEL   8'h7f
`define BTI_MASK_TIME       8'h7f
`define BTI_MASK_FADE       8'hff

// Reset values.
`define BTI_RST_REG         8'h00

// Sink channel that the second sensor borrows.
`define BTI_SECOND_CHAN     5

// Timeout tick: one second at a 10 ns clock.
`define BTI_SECOND_MS       1000
`define BTI_CLK_PERIOD_NS   10
`define BTI_TICKS_PER_SEC   ((`BTI_SECOND_MS * 1000000) / `BTI_CLK_PERIOD_NS)

`endif

// [inc/bti_pkg.sv]
package bti_pkg;

   // One register access from the serial interface engine.
   typedef struct packed {
      logic       wr;     // Write strobe, one cycle.
      logic       rd;     // Read strobe, one cycle.
      logic [7:0] addr;   // Register offset.
      logic [7:0] wdata;  // Write data.
   } bti_req_type;

   // Fault and light sensor inputs from the analog side.
   typedef struct packed {
      logic       short_fault;   // Output short or overload event.
      logic       thermal;       // Over temperature event.
      logic       overvoltage;   // Output over voltage event.
      logic [1:0] main_light_input;    // Main comparator level code.
      logic [1:0] second_light_input;  // Second comparator level code.
      logic       at_max;        // Backlight current has reached maximum.
   } bti_sense_type;

   // Backlight timer states, Gray coded along the usual path.
   typedef enum logic [2:0] {
      BL_IDLE = 3'h0,   // Backlight not running.
      BL_RAMP = 3'h1,   // Rising to maximum current.
      BL_HOLD = 3'h3,   // Full current, dim countdown.
      BL_LATE = 3'h2,   // Off countdown.
      BL_DARK = 3'h6    // Off timeout reached.
   } bti_state_type;

endpackage

// [src/bti_regs.sv]
`timescale 1ns/1ps
`include "bti_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module bti_regs #(
   parameter int TICKS_PER_SEC = `BTI_TICKS_PER_SEC  // Clocks per second.
) (
   input  wire logic                 i_mclk,        // System clock.
   input  wire logic                 i_reset,       // Async reset, high.
   input  wire bti_pkg::bti_req_type i_reg_req,     // Register access.
   input  wire bti_pkg::bti_sense_type i_sense,     // Faults and sensors.
   output logic [7:0]                o_reg_rdata,   // Read data.
   output logic                      o_irq,         // Host interrupt, high.
   output logic                      o_backlight_run, // Backlight running.
   output logic                      o_dim_active,  // Dim current selected.
   output logic [1:0]                o_brightness_level, // Level code.
   output logic [1:0]                o_transfer_law, // Law code.
   output logic                      o_fade_override, // Fade override on.
   output logic [3:0]                o_fade_in_rate,  // Fade in code.
   output logic [3:0]                o_fade_out_rate, // Fade out code.
   output logic                      o_second_sensor_enable, // Sensor two on.
   output logic [6:0]                o_sink_on,     // Backlight sink drives.
   output logic [6:0]                o_sink_independent // Independent sinks.
);

   //////////////////////////////////////////////////////////////////////////
   // Parameter check.
   if (TICKS_PER_SEC < 2) begin : g_bad_tick
      $error("TICKS_PER_SEC must be at least 2.");
   end

   //////////////////////////////////////////////////////////////////////////
   // Register storage.
   logic [7:0] mode;        // Mode register.
   logic [7:0] status;      // Sticky event flags.
   logic [7:0] irq_enable;  // Interrupt enables.
   logic [7:0] config_reg;  // Backlight configuration.
   logic [7:0] sink_select; // Sink independent selects.
   logic [7:0] off_time;    // Off timeout seconds.
   logic [7:0] dim_time;    // Dim timeout seconds.
   logic [7:0] fade_rate;   // Fade rates.

   // Write decode per register.
   wire wr_mode   = i_reg_req.wr && i_reg_req.addr == `BTI_OFS_MODE;
   wire wr_status = i_reg_req.wr && i_reg_req.addr == `BTI_OFS_STATUS;
   wire wr_irq_en = i_reg_req.wr && i_reg_req.addr == `BTI_OFS_IRQ_EN;
   wire wr_config = i_reg_req.wr && i_reg_req.addr == `BTI_OFS_CONFIG;
   wire wr_sink   = i_reg_req.wr && i_reg_req.addr == `BTI_OFS_SINK_SEL;
   wire wr_off    = i_reg_req.wr && i_reg_req.addr == `BTI_OFS_OFF_TIME;
   wire wr_dim    = i_reg_req.wr && i_reg_req.addr == `BTI_OFS_DIM_TIME;
   wire wr_fade   = i_reg_req.wr && i_reg_req.addr == `BTI_OFS_FADE;
   wire [7:0] wdata = i_reg_req.wdata;

   //////////////////////////////////////////////////////////////////////////
   // Event detection for the status flags.
   logic [1:0] prev_main;    // Main level seen last cycle.
   logic [1:0] prev_second;  // Second level seen last cycle.

   // A comparator flag sets when its level code changes; the second one only while sensor two is enabled.
   wire main_trip   = i_sense.main_light_input != prev_main;
   wire second_trip = i_sense.second_light_input != prev_second &&
                      config_reg[`BTI_CFG_SECOND_EN];
   wire [7:0] flag_set = {3'h0, i_sense.short_fault, i_sense.thermal,
                          i_sense.overvoltage, second_trip, main_trip};
   wire [7:0] flag_clr = wr_status ? (wdata & `BTI_MASK_STATUS) : 8'h00;
   // Set wins over a clear arriving in the same cycle.
   wire [7:0] next_status = ((status & ~flag_clr) | flag_set) &
                            `BTI_MASK_STATUS;
   wire next_irq = |(next_status & irq_enable);

   // Remember comparator levels for change detection.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         prev_main   <= 2'h0;
         prev_second <= 2'h0;
      end else begin
         prev_main   <= i_sense.main_light_input;
         prev_second <= i_sense.second_light_input;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Backlight level steering and mode control.
   wire bl_enable  = mode[`BTI_MODE_BL_ON] && mode[`BTI_MODE_ACTIVE];
   wire auto_level = mode[`BTI_MODE_AUTO];
   // The steering sensor is the second one only when selected.
   wire [1:0] steer_level = config_reg[`BTI_CFG_STEER] ?
                            i_sense.second_light_input :
                            i_sense.main_light_input;
   // Automatic response replaces whatever software wrote.
   wire [1:0] next_level = auto_level ? steer_level :
                           wr_config ? wdata[`BTI_CFG_LVL_HI:`BTI_CFG_LVL_LO] :
                           config_reg[`BTI_CFG_LVL_HI:`BTI_CFG_LVL_LO];
   wire [7:0] cfg_write = wr_config ? wdata : config_reg;
   wire [7:0] next_config = {cfg_write[7:5], next_level, cfg_write[2:0]} &
                            `BTI_MASK_CONFIG;

   //////////////////////////////////////////////////////////////////////////
   // One-second tick and countdown state.
   bti_pkg::bti_state_type state;      // Timer state.
   bti_pkg::bti_state_type next_state; // Timer next state.
   logic [31:0] tick_cnt;  // Clocks within the current second.
   logic [6:0]  sec_cnt;   // Whole seconds in the current state.

   wire sec_tick  = tick_cnt == 32'(TICKS_PER_SEC - 1);
   wire [6:0] dim_secs = dim_time[6:0];
   wire [6:0] off_secs = off_time[6:0];
   wire dim_done  = sec_tick && sec_cnt == dim_secs - 7'h01;
   wire off_done  = sec_tick && sec_cnt == off_secs - 7'h01;
   wire state_chg = next_state != state;

   // Next state of the backlight countdown.
   always_comb begin
      next_state = state;
      if (!bl_enable) begin
         next_state = bti_pkg::BL_IDLE;
      end else begin
         case (state)
            bti_pkg::BL_IDLE: begin
               next_state = bti_pkg::BL_RAMP;
            end
            bti_pkg::BL_RAMP: begin
               if (i_sense.at_max) begin
                  next_state = bti_pkg::BL_HOLD;
               end
            end
            bti_pkg::BL_HOLD: begin
               // Without a dim timeout the off count begins at once.
               if (dim_secs == 7'h00 || dim_done) begin
                  next_state = bti_pkg::BL_LATE;
               end
            end
            bti_pkg::BL_LATE: begin
               if (off_secs != 7'h00 && off_done) begin
                  next_state = bti_pkg::BL_DARK;
               end
            end
            bti_pkg::BL_DARK: begin
               next_state = bti_pkg::BL_DARK;
            end
            default: begin
               next_state = bti_pkg::BL_IDLE;
            end
         endcase
      end
   end

   // Hardware sets the dim flag at dim expiry; it needs the enable.
   wire hw_dim = state == bti_pkg::BL_HOLD && dim_secs != 7'h00 &&
                 dim_done;
   wire next_dim = !bl_enable ? 1'b0 :
                   hw_dim ? 1'b1 :
                   wr_mode ? wdata[`BTI_MODE_DIM] :
                   mode[`BTI_MODE_DIM];
   wire [7:0] mode_write = wr_mode ? (wdata & `BTI_MASK_MODE) : mode;
   wire [7:0] next_mode = {mode_write[7:5], next_dim, mode_write[3:0]} &
                          `BTI_MASK_MODE;

   // Seconds divider restarts on every state change.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         tick_cnt <= 32'h0;
         sec_cnt  <= 7'h00;
      end else if (state_chg) begin
         tick_cnt <= 32'h0;
         sec_cnt  <= 7'h00;
      end else if (sec_tick) begin
         tick_cnt <= 32'h0;
         sec_cnt  <= sec_cnt + 7'h01;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
      end
   end

   // Timer state; dropping the enable returns it to idle for a restart.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         state <= bti_pkg::BL_IDLE;
      end else begin
         state <= next_state;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Register writes; reserved bits are masked off.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         mode        <= `BTI_RST_REG;
         status      <= `BTI_RST_REG;
         irq_enable  <= `BTI_RST_REG;
         config_reg  <= `BTI_RST_REG;
         sink_select <= `BTI_RST_REG;
         off_time    <= `BTI_RST_REG;
         dim_time    <= `BTI_RST_REG;
         fade_rate   <= `BTI_RST_REG;
      end else begin
         mode       <= next_mode;
         status     <= next_status;
         config_reg <= next_config;
         if (wr_irq_en) begin
            irq_enable <= wdata & `BTI_MASK_IRQ_EN;
         end
         if (wr_sink) begin
            sink_select <= wdata & `BTI_MASK_SINK_SEL;
         end
         if (wr_off) begin
            off_time <= wdata & `BTI_MASK_TIME;
         end
         if (wr_dim) begin
            dim_time <= wdata & `BTI_MASK_TIME;
         end
         if (wr_fade) begin
            fade_rate <= wdata & `BTI_MASK_FADE;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read data mux; unmapped offsets read zero.
   wire [7:0] rd_mux =
      i_reg_req.addr == `BTI_OFS_MODE     ? mode        :
      i_reg_req.addr == `BTI_OFS_STATUS   ? status      :
      i_reg_req.addr == `BTI_OFS_IRQ_EN   ? irq_enable  :
      i_reg_req.addr == `BTI_OFS_CONFIG   ? config_reg  :
      i_reg_req.addr == `BTI_OFS_SINK_SEL ? sink_select :
      i_reg_req.addr == `BTI_OFS_OFF_TIME ? off_time    :
      i_reg_req.addr == `BTI_OFS_DIM_TIME ? dim_time    :
      i_reg_req.addr == `BTI_OFS_FADE     ? fade_rate   : 8'h00;

   //////////////////////////////////////////////////////////////////////////
   // Backlight run level and per-channel sink routing.
   wire bl_running = bl_enable && state != bti_pkg::BL_DARK &&
                     config_reg[`BTI_CFG_LVL_HI:`BTI_CFG_LVL_LO] != 2'h3;
   logic [6:0] next_sink_on;   // Backlight drive per channel.
   logic [6:0] next_sink_ind;  // Independent flag per channel.

   for (genvar ch = 0; ch < 7; ch++) begin : g_chan
      // Sensor two takes over channel six's pin.
      wire kill = ch == `BTI_SECOND_CHAN &&
                  config_reg[`BTI_CFG_SECOND_EN];
      assign next_sink_ind[ch] = sink_select[ch] && !kill;
      assign next_sink_on[ch]  = !sink_select[ch] && !kill &&
                                 bl_running;
   end

   //////////////////////////////////////////////////////////////////////////
   // Registered outputs.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_reg_rdata            <= 8'h00;
         o_irq                  <= 1'b0;
         o_backlight_run        <= 1'b0;
         o_dim_active           <= 1'b0;
         o_brightness_level     <= 2'h0;
         o_transfer_law         <= 2'h0;
         o_fade_override        <= 1'b0;
         o_fade_in_rate         <= 4'h0;
         o_fade_out_rate        <= 4'h0;
         o_second_sensor_enable <= 1'b0;
         o_sink_on              <= 7'h00;
         o_sink_independent     <= 7'h00;
      end else begin
         if (i_reg_req.rd) begin
            o_reg_rdata <= rd_mux;
         end
         o_irq              <= next_irq;
         o_backlight_run    <= bl_running;
         o_dim_active       <= mode[`BTI_MODE_DIM] && bl_enable;
         o_brightness_level <= config_reg[`BTI_CFG_LVL_HI:`BTI_CFG_LVL_LO];
         o_transfer_law     <= config_reg[`BTI_CFG_LAW_HI:`BTI_CFG_LAW_LO];
         o_fade_override    <= config_reg[`BTI_CFG_FADE_OVR];
         o_fade_in_rate     <= fade_rate[3:0];
         o_fade_out_rate    <= fade_rate[7:4];
         o_second_sensor_enable <= config_reg[`BTI_CFG_SECOND_EN];
         o_sink_on          <= next_sink_on;
         o_sink_independent <= next_sink_ind;
      end
   end

endmodule

// [verif/bti_host.sv]
`timescale 1ns/1ps
// Host side of the register port: one strobed access at a time.
module bti_host (
   input  wire logic           i_mclk,  // System clock.
   input  wire logic [7:0]     i_rdata, // Read data from the bank.
   output bti_pkg::bti_req_type o_req   // Register access.
);
   initial o_req = '0;
   // Writes a byte; a one at a status bit clears that flag.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      #1;
      o_req = '{1'b1, 1'b0, a, d};
      @(posedge i_mclk);
      #1;
      o_req = '{1'b0, 1'b0, ~a, ~d};
   endtask
   // Reads a byte; the answer is present just after the taking edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      #1;
      o_req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_mclk);
      #1;
      o_req = '{1'b0, 1'b0, ~a, 8'hff};
      d = i_rdata;
   endtask
endmodule

// [verif/bti_regs_assertions.sv]
`timescale 1ns/1ps
`include "bti_cfg.svh"
// Checks the register bank from its ports alone.
module bti_regs_assertions (
   input wire logic                 i_mclk,                 // Clock.
   input wire logic                 i_reset,                // Reset, high.
   input wire bti_pkg::bti_req_type i_reg_req,              // Access.
   input wire logic [7:0]           o_reg_rdata,            // Read data.
   input wire logic                 o_irq,                  // Interrupt.
   input wire logic                 o_backlight_run,        // Running.
   input wire logic                 o_dim_active,           // Dimmed.
   input wire logic                 o_second_sensor_enable, // Sensor two.
   input wire logic [6:0]           o_sink_on,              // Tied sinks.
   input wire logic [6:0]           o_sink_independent      // Free sinks.
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   logic [4:0] en_q;     // Shadow of the interrupt enables.
   logic [1:0] mode_q;   // Shadow of the active and enable bits.
   logic [2:0] run_h;    // Recent history of enabled and active.
   logic [2:0] on_h;     // Recent history of the enable bit.
   logic       wr_en;    // Write to the enable register.
   logic       wr_mode;  // Write to the mode register.
   assign wr_en = i_reg_req.wr && i_reg_req.addr == `BTI_OFS_IRQ_EN;
   assign wr_mode = i_reg_req.wr && i_reg_req.addr == `BTI_OFS_MODE;
   // Mirrors host writes; the history allows a few cycles of lag.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         en_q <= 5'h00;
         mode_q <= 2'h0;
         run_h <= 3'h0;
         on_h <= 3'h0;
      end else begin
         en_q <= wr_en ? i_reg_req.wdata[4:0] : en_q;
         mode_q <= wr_mode ? {i_reg_req.wdata[5], i_reg_req.wdata[0]}
                           : mode_q;
         run_h <= {run_h[1:0], &mode_q};
         on_h <= {on_h[1:0], mode_q[0]};
      end
   end
   property p_unmapped;
      i_reg_req.rd && i_reg_req.addr > 8'h08 |=> o_reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read");
   property p_rsvd;
      i_reg_req.rd && i_reg_req.addr inside {[8'h01:8'h07]}
         |=> !o_reg_rdata[7];
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bit set");
   property p_irq_gate;
      en_q == 5'h00 && $past(en_q) == 5'h00 |-> !o_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq ungated");
   property p_irq_hold;
      o_irq && !i_reg_req.wr && !$past(i_reg_req.wr) |=> o_irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("irq lost");
   property p_second;
      o_second_sensor_enable |-> !o_sink_on[5] && !o_sink_independent[5];
   endproperty
   a_second: assert property (p_second)
      else $error("sink six on");
   // The read two cycles after a write returns the masked write data.
   property p_wr_rd;
      i_reg_req.wr && i_reg_req.addr == 8'h05 ##2
      i_reg_req.rd && i_reg_req.addr == 8'h05
         |=> o_reg_rdata == ($past(i_reg_req.wdata, 3) & 8'h7f);
   endproperty
   a_wr_rd: assert property (p_wr_rd)
      else $error("sink readback");
   // Channel six is left out, since sensor two may claim it.
   property p_sink_copy;
      i_reg_req.wr && i_reg_req.addr == 8'h05 |-> ##2
         {1'b0, o_sink_independent[6], 1'b0, o_sink_independent[4:0]} ==
         ($past(i_reg_req.wdata, 2) & 8'h5f);
   endproperty
   a_sink_copy: assert property (p_sink_copy)
      else $error("sink copy");
   property p_run;
      o_backlight_run |-> |run_h;
   endproperty
   a_run: assert property (p_run)
      else $error("run while off");
   property p_dim;
      o_dim_active |-> |on_h;
   endproperty
   a_dim: assert property (p_dim)
      else $error("dim while off");
   c_irq: cover property ($rose(o_irq));
   c_dim: cover property ($rose(o_dim_active));
   c_off: cover property ($fell(o_backlight_run));
endmodule
bind bti_regs bti_regs_assertions u_chk (.i_mclk, .i_reset, .i_reg_req,
   .o_reg_rdata, .o_irq, .o_backlight_run, .o_dim_active,
   .o_second_sensor_enable, .o_sink_on, .o_sink_independent);

// [verif/bti_regs_tb.sv]
`timescale 1ns/1ps
`include "bti_cfg.svh"
module bti_regs_tb;
   logic                   i_mclk;
   logic                   i_reset;
   bti_pkg::bti_req_type   i_reg_req;
   bti_pkg::bti_sense_type i_sense;
   logic [7:0]             o_reg_rdata;
   logic                   o_irq, o_backlight_run, o_dim_active;
   logic                   o_fade_override, o_second_sensor_enable;
   logic [1:0]             o_brightness_level, o_transfer_law;
   logic [3:0]             o_fade_in_rate, o_fade_out_rate;
   logic [6:0]             o_sink_on, o_sink_independent;
   int                     num_errors = 0;
   int                     compares = 0;
   int                     cyc = 0;
   bti_regs #(.TICKS_PER_SEC(10)) DUT (.i_mclk, .i_reset, .i_reg_req,
      .i_sense, .o_reg_rdata, .o_irq, .o_backlight_run, .o_dim_active,
      .o_brightness_level, .o_transfer_law, .o_fade_override,
      .o_fade_in_rate, .o_fade_out_rate, .o_second_sensor_enable,
      .o_sink_on, .o_sink_independent);
   bti_host u_host (.i_mclk, .i_rdata(o_reg_rdata), .o_req(i_reg_req));
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) cyc++;
   task automatic chk(input logic [7:0] g, input logic [7:0] e,
                      input string m);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                        input string m);
      logic [7:0] v;
      u_host.rd(a, v);
      chk(v, e, m);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   // Waits for a level, looking only where outputs have settled.
   task automatic wait_on(ref logic s, input logic v);
      int t = cyc;
      while (s !== v && cyc - t < 200) begin
         @(posedge i_mclk);
         #1;
      end
      if (s !== v) begin
         num_errors++;
         $display("BAD %0t wait for level timed out", $time);
      end
   endtask
   task automatic t_regs();
      logic [7:0] msk [7] = '{8'h1f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'hff, 8'h00};
      for (int a = 1; a <= 9; a++) rdchk(8'(a), 8'h00, "reset");
      for (int a = 3; a <= 9; a++) begin
         u_host.wr(8'(a), 8'hff);
         rdchk(8'(a), msk[a-3], "mask");
      end
      chk({1'b0, o_sink_independent}, 8'h5f, "sink six");
      chk({o_brightness_level, o_transfer_law, o_fade_in_rate}, 8'hff,
          "fields");
      $display("t_regs done");
   endtask
   task automatic t_fields();
      for (int i = 0; i < 4; i++) begin
         u_host.wr(`BTI_OFS_CONFIG, {3'h0, 2'(i), 2'(3 - i), i[0]});
         u_host.wr(`BTI_OFS_FADE, {4'(i), 4'(15 - i)});
         u_host.wr(`BTI_OFS_SINK_SEL, 8'(1 << i));
         tick(1);
         chk({o_brightness_level, o_transfer_law, o_fade_out_rate},
             {2'(i), 2'(3 - i), 4'(i)}, "level law");
         chk({o_fade_override, o_second_sensor_enable, 2'h0, o_fade_in_rate},
             {i[0], 3'h0, 4'(15 - i)}, "fade");
         chk({1'b0, o_sink_independent}, 8'(1 << i), "sink sel");
      end
      $display("t_fields done");
   endtask
   task automatic t_irq();
      for (int i = 2; i <= 4; i++) begin
         u_host.wr(`BTI_OFS_IRQ_EN, 8'h00);
         {i_sense.short_fault, i_sense.thermal, i_sense.overvoltage} =
            3'(1 << (i - 2));
         tick(1);
         {i_sense.short_fault, i_sense.thermal, i_sense.overvoltage} = 3'h0;
         tick(2);
         chk({7'h0, o_irq}, 8'h00, "masked irq");
         rdchk(`BTI_OFS_STATUS, 8'(1 << i), "flag set");
         u_host.wr(`BTI_OFS_STATUS, 8'h00);
         u_host.wr(`BTI_OFS_IRQ_EN, 8'(1 << i));
         tick(2);
         chk({7'h0, o_irq}, 8'h01, "irq raised");
         u_host.wr(`BTI_OFS_STATUS, 8'(1 << i));
         rdchk(`BTI_OFS_STATUS, 8'h00, "flag cleared");
         chk({7'h0, o_irq}, 8'h00, "irq dropped");
      end
      $display("t_irq done");
   endtask
   task automatic t_auto();
      u_host.wr(`BTI_OFS_IRQ_EN, 8'h00);
      u_host.wr(`BTI_OFS_CONFIG, 8'h00);
      u_host.wr(`BTI_OFS_MODE, 8'h02);
      i_sense.main_light_input = 2'h1;
      tick(3);
      rdchk(`BTI_OFS_STATUS, 8'h01, "main flag");
      rdchk(`BTI_OFS_CONFIG, 8'h08, "auto main");
      u_host.wr(`BTI_OFS_CONFIG, 8'h78);
      i_sense.second_light_input = 2'h2;
      tick(3);
      rdchk(`BTI_OFS_STATUS, 8'h03, "second flag");
      rdchk(`BTI_OFS_CONFIG, 8'h70, "auto second");
      u_host.wr(`BTI_OFS_STATUS, 8'h03);
      u_host.wr(`BTI_OFS_MODE, 8'h00);
      u_host.wr(`BTI_OFS_CONFIG, 8'h00);
      $display("t_auto done");
   endtask
   task automatic t_timer();
      int t0;
      u_host.wr(`BTI_OFS_SINK_SEL, 8'h00);
      u_host.wr(`BTI_OFS_DIM_TIME, 8'h02);
      u_host.wr(`BTI_OFS_OFF_TIME, 8'h03);
      u_host.wr(`BTI_OFS_MODE, 8'h01);
      tick(5);
      chk({7'h0, o_backlight_run}, 8'h00, "standby");
      u_host.wr(`BTI_OFS_MODE, 8'h21);
      tick(40);
      chk({6'h0, o_backlight_run, o_dim_active}, 8'h02, "no max");
      chk({1'b0, o_sink_on}, 8'h7f, "tied sinks");
      i_sense.at_max = 1'b1;
      t0 = cyc;
      wait_on(o_dim_active, 1'b1);
      chk(8'((cyc - t0 + 5) / 10), 8'h02, "dim time");
      t0 = cyc;
      rdchk(`BTI_OFS_MODE, 8'h31, "dim flag");
      wait_on(o_backlight_run, 1'b0);
      chk(8'((cyc - t0 + 5) / 10), 8'h03, "off time");
      u_host.wr(`BTI_OFS_MODE, 8'h00);
      u_host.wr(`BTI_OFS_MODE, 8'h21);
      wait_on(o_backlight_run, 1'b1);
      chk({6'h0, o_backlight_run, o_dim_active}, 8'h02, "restart");
      // The dim countdown must start again from zero after re-enabling.
      t0 = cyc;
      wait_on(o_dim_active, 1'b1);
      chk(8'((cyc - t0 + 5) / 10), 8'h02, "dim again");
      // Level code three turns the backlight off.
      u_host.wr(`BTI_OFS_CONFIG, 8'h18);
      tick(2);
      chk({o_backlight_run, o_sink_on}, 8'h00, "level off");
      $display("t_timer done");
   endtask
   task automatic end_of_test();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run length.
   initial begin
      #50000;
      num_errors++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
   end
   initial begin
      i_reset = 1'b1;
      i_sense = '0;
      tick(3);
      i_reset = 1'b0;
      t_regs();
      t_fields();
      t_irq();
      t_auto();
      t_timer();
      end_of_test();
   end
endmodule
